/* File: logic/isu_top.v */
// interrupt status collector for the upper event sources, apb slave
// assumes event inputs synchronous to pclk; pclken freezes all state
//
// Overview of operation
// - a status read returns pending bits, then clears them
// - writes to the status register are ignored
// - status bits record events regardless of mask bits
// - interrupt pin active only when a set bit is also enabled
// - hard and soft reset load status value 03008000h
// - bit 25 set when a requested transmit reset finishes
// - bit 24 set when a requested receive reset finishes
// - bit 23 set when parity error flag rises; cleared by read
// - bit 22 set when device signals a system error
// - bit 21 set on master abort of own bus-master cycle
// - bit 20 set on target abort of own bus-master cycle
// - bit 16 set on receive status fifo overflow
// - bit 15 reads as or of bits 25 down to 16
// - bit 14 set when the phy raises its interrupt
// - bit 13 set when a wake condition is detected
// - bit 12 set when software sets its interrupt request command bit
// - bit 11 set when a statistics counter hits its threshold
// - bit 10 set on transmit data fifo underrun
// - bit 9 set when transmit engine enters idle from running
// - transmit engine goes idle on null link or unowned descriptor
// - bit 8 set when a transmit frame fails
// - mask bits clear on reset; a one enables the interrupt
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "isu_defs.vh"

module isu_top #(
    parameter ADDR_W = 8
) (
    input wire pclk,
    input wire presetn,
    input wire pclken,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire soft_reset,
    input wire tx_reset_finished,
    input wire rx_reset_finished,
    input wire parity_error_seen,
    input wire system_error_signalled,
    input wire master_abort_received,
    input wire target_abort_received,
    input wire rx_status_fifo_overflow,
    input wire phy_irq,
    input wire wake_on_network,
    input wire statistics_threshold_event,
    input wire tx_fifo_underflow,
    input wire tx_frame_failed,
    input wire tx_desc_fetched,
    input wire tx_desc_link_null,
    input wire tx_desc_owned,
    output wire irq_n,
    output wire tx_reset_req,
    output wire rx_reset_req,
    output wire tx_engine_run
);

    ////////////////////////////////////////////////////////////////////
    // functions

    // match a bus address against a byte offset, upper bits included
    function addr_hit;
        input [ADDR_W-1:0] addr;
        input [7:0] offset;
        begin
            addr_hit = (addr == {{(ADDR_W-8){1'b0}}, offset});
        end
    endfunction

    // expand byte strobes into a bit mask for one word
    function [31:0] lane_mask;
        input [3:0] strb;
        begin
            lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // declarations

    localparam TX_ST_IDLE = 1'b0;
    localparam TX_ST_RUN = 1'b1;
    reg ack_reg, ack_next;
    reg err_reg, err_next;
    reg [31:0] rdata_reg, rdata_next;
    reg [31:0] clr_pend_reg, clr_pend_next;
    reg [31:0] mask_reg, mask_next;
    reg tx_state_reg, tx_state_next;
    reg tx_rst_req_reg, tx_rst_req_next;
    reg rx_rst_req_reg, rx_rst_req_next;
    reg tx_rst_pend_reg, tx_rst_pend_next;
    reg rx_rst_pend_reg, rx_rst_pend_next;
    reg parity_dly_reg;
    reg irq_n_reg;
    reg [31:0] set_vec, clr_vec;
    wire [31:0] stored, status_view, cmd_rd;
    wire summary, access, done;
    wire hit_cmd, hit_status, hit_mask, mapped;
    wire wr_cmd, cmd_soft, cmd_tx_en, cmd_tx_rst, cmd_rx_rst, cmd_swi, any_soft;
    wire tx_end_of_list, tx_went_idle;

    ////////////////////////////////////////////////////////////////////
    // bus decode

    assign access = psel & penable;
    // request completes at the edge where pready is seen high
    assign done = access & ack_reg;

    assign hit_cmd = addr_hit(paddr, `ISU_CMD_OFFSET);
    assign hit_status = addr_hit(paddr, `ISU_STATUS_OFFSET);
    assign hit_mask = addr_hit(paddr, `ISU_MASK_OFFSET);
    assign mapped = hit_cmd | hit_status | hit_mask;

    assign wr_cmd = done & pwrite & hit_cmd & pstrb[0];
    assign cmd_soft = wr_cmd & pwdata[`ISU_CMD_SOFT_RESET];
    assign cmd_tx_en = wr_cmd & pwdata[`ISU_CMD_TX_ENABLE];
    assign cmd_tx_rst = wr_cmd & pwdata[`ISU_CMD_TX_RESET];
    assign cmd_rx_rst = wr_cmd & pwdata[`ISU_CMD_RX_RESET];
    assign cmd_swi = wr_cmd & pwdata[`ISU_CMD_SW_INT];
    assign any_soft = soft_reset | cmd_soft;

    ////////////////////////////////////////////////////////////////////
    // status view

    assign summary = |stored[`ISU_SUMMARY_HI:`ISU_SUMMARY_LO];
    // only implemented bits are ever stored, so the rest read zero
    assign status_view = (stored & `ISU_STATUS_STORED) |
        ({31'h00000000, summary} << `ISU_UPPER_ERROR_SUMMARY);

    assign cmd_rd = ({31'h00000000, tx_state_reg} << `ISU_CMD_TX_RUNNING) |
        ({31'h00000000, tx_rst_pend_reg} << `ISU_CMD_TX_RESET_PEND) |
        ({31'h00000000, rx_rst_pend_reg} << `ISU_CMD_RX_RESET_PEND);

    ////////////////////////////////////////////////////////////////////
    // apb handshake and read data

    // one wait state: pready rises in the second access cycle
    always @* begin
        ack_next = ack_reg;
        err_next = err_reg;
        rdata_next = rdata_reg;
        clr_pend_next = clr_pend_reg;
        if (done) begin
            ack_next = 1'b0;
            err_next = 1'b0;
            clr_pend_next = 32'h00000000;
        end else if (access) begin
            ack_next = 1'b1;
            err_next = ~mapped;
            rdata_next = 32'h00000000;
            clr_pend_next = 32'h00000000;
            if (!pwrite && hit_status) begin
                rdata_next = status_view;
                // clear only what was returned, so later events survive
                clr_pend_next = status_view;
            end else if (!pwrite && hit_mask) begin
                rdata_next = mask_reg;
            end else if (!pwrite && hit_cmd) begin
                rdata_next = cmd_rd;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            clr_pend_reg <= 32'h00000000;
        end else if (pclken) begin
            ack_reg <= ack_next;
            err_reg <= err_next;
            rdata_reg <= rdata_next;
            clr_pend_reg <= clr_pend_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt enable mask

    always @* begin
        mask_next = mask_reg;
        if (any_soft) begin
            mask_next = `ISU_MASK_RESET;
        end else if (done && pwrite && hit_mask) begin
            mask_next = (mask_reg & ~lane_mask(pstrb)) |
                (pwdata & lane_mask(pstrb));
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= `ISU_MASK_RESET;
        end else if (pclken) begin
            mask_reg <= mask_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transmit engine activity tracker

    // fetch of a descriptor with null link or not owned ends the list
    assign tx_end_of_list = tx_desc_fetched &
        (tx_desc_link_null | ~tx_desc_owned);
    assign tx_went_idle = (tx_state_reg == TX_ST_RUN) &&
        (tx_state_next == TX_ST_IDLE);

    always @* begin
        tx_state_next = tx_state_reg;
        case (tx_state_reg)
            TX_ST_IDLE: begin
                if (cmd_tx_en && !cmd_tx_rst && !any_soft) begin
                    tx_state_next = TX_ST_RUN;
                end
            end
            TX_ST_RUN: begin
                if (tx_end_of_list || cmd_tx_rst || any_soft) begin
                    tx_state_next = TX_ST_IDLE;
                end
            end
            default: begin
                tx_state_next = TX_ST_IDLE;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_reg <= TX_ST_IDLE;
        end else if (pclken) begin
            tx_state_reg <= tx_state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // reset requests to the transmit and receive engines

    // completion only counts while a request is outstanding
    always @* begin
        tx_rst_req_next = cmd_tx_rst;
        rx_rst_req_next = cmd_rx_rst;
        tx_rst_pend_next = tx_rst_pend_reg;
        rx_rst_pend_next = rx_rst_pend_reg;
        if (any_soft) begin
            tx_rst_req_next = 1'b0;
            rx_rst_req_next = 1'b0;
            tx_rst_pend_next = 1'b0;
            rx_rst_pend_next = 1'b0;
        end else begin
            if (cmd_tx_rst) begin
                tx_rst_pend_next = 1'b1;
            end else if (tx_reset_finished) begin
                tx_rst_pend_next = 1'b0;
            end
            if (cmd_rx_rst) begin
                rx_rst_pend_next = 1'b1;
            end else if (rx_reset_finished) begin
                rx_rst_pend_next = 1'b0;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_rst_req_reg <= 1'b0;
            rx_rst_req_reg <= 1'b0;
            tx_rst_pend_reg <= 1'b0;
            rx_rst_pend_reg <= 1'b0;
            parity_dly_reg <= 1'b0;
        end else if (pclken) begin
            tx_rst_req_reg <= tx_rst_req_next;
            rx_rst_req_reg <= rx_rst_req_next;
            tx_rst_pend_reg <= tx_rst_pend_next;
            rx_rst_pend_reg <= rx_rst_pend_next;
            parity_dly_reg <= parity_error_seen;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // event collection

    // set vector is built without looking at the mask
    always @* begin
        set_vec = 32'h00000000;
        set_vec[`ISU_TX_RESET_DONE] =
            tx_rst_pend_reg & tx_reset_finished;
        set_vec[`ISU_RX_RESET_DONE] =
            rx_rst_pend_reg & rx_reset_finished;
        // rising edge only: the config flag may stay set for long
        set_vec[`ISU_PARITY_ERROR_SEEN] =
            parity_error_seen & ~parity_dly_reg;
        set_vec[`ISU_SYSTEM_ERROR_SIGNALLED] =
            system_error_signalled;
        set_vec[`ISU_MASTER_ABORT_RECEIVED] =
            master_abort_received;
        set_vec[`ISU_TARGET_ABORT_RECEIVED] =
            target_abort_received;
        set_vec[`ISU_RX_STATUS_FIFO_OVERFLOW] =
            rx_status_fifo_overflow;
        set_vec[`ISU_PHY_EVENT] = phy_irq;
        set_vec[`ISU_WAKE_ON_NETWORK] = wake_on_network;
        set_vec[`ISU_SOFTWARE_INTERRUPT_REQUEST] = cmd_swi;
        set_vec[`ISU_STATISTICS_THRESHOLD_EVENT] =
            statistics_threshold_event;
        set_vec[`ISU_TX_FIFO_UNDERFLOW] = tx_fifo_underflow;
        set_vec[`ISU_TX_ENGINE_IDLE] = tx_went_idle;
        set_vec[`ISU_TX_FRAME_FAILED] = tx_frame_failed;
        set_vec = set_vec & `ISU_STATUS_STORED;
    end

    // status writes never reach the flags; only a completed read clears
    always @* begin
        clr_vec = 32'h00000000;
        if (done && !pwrite && hit_status) begin
            clr_vec = clr_pend_reg;
        end
    end

    isu_event_reg #(
        .WIDTH(32),
        .RESET_VAL(`ISU_STATUS_RESET & `ISU_STATUS_STORED)
    ) u_status (
        .clk(pclk),
        .rst_n(presetn),
        .ce(pclken),
        .soft_rst(any_soft),
        .set_vec(set_vec),
        .clr_vec(clr_vec),
        .flags(stored)
    );

    ////////////////////////////////////////////////////////////////////
    // interrupt pin

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_n_reg <= 1'b1;
        end else if (pclken) begin
            irq_n_reg <= ~|(status_view & mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata = rdata_reg;
    assign pready = ack_reg;
    assign pslverr = err_reg;
    assign irq_n = irq_n_reg;
    assign tx_reset_req = tx_rst_req_reg;
    assign rx_reset_req = rx_rst_req_reg;
    assign tx_engine_run = tx_state_reg;

endmodule

`default_nettype wire

/* File: shared/isu_defs.vh */
// interrupt status (upper sources) block: offsets, fields, reset values
// assumes a 32-bit apb slave and a byte address space of 256 bytes
`ifndef ISU_DEFS_VH
`define ISU_DEFS_VH

// register byte offsets
`define ISU_CMD_OFFSET 8'h00
`define ISU_STATUS_OFFSET 8'h10
`define ISU_MASK_OFFSET 8'h14

// status register values
`define ISU_STATUS_RESET 32'h03008000
`define ISU_STATUS_STORED 32'h03F17F00
`define ISU_MASK_RESET 32'h00000000

// status bit positions
`define ISU_TX_RESET_DONE 25
`define ISU_RX_RESET_DONE 24
`define ISU_PARITY_ERROR_SEEN 23
`define ISU_SYSTEM_ERROR_SIGNALLED 22
`define ISU_MASTER_ABORT_RECEIVED 21
`define ISU_TARGET_ABORT_RECEIVED 20
`define ISU_RX_STATUS_FIFO_OVERFLOW 16
`define ISU_UPPER_ERROR_SUMMARY 15
`define ISU_PHY_EVENT 14
`define ISU_WAKE_ON_NETWORK 13
`define ISU_SOFTWARE_INTERRUPT_REQUEST 12
`define ISU_STATISTICS_THRESHOLD_EVENT 11
`define ISU_TX_FIFO_UNDERFLOW 10
`define ISU_TX_ENGINE_IDLE 9
`define ISU_TX_FRAME_FAILED 8
`define ISU_SUMMARY_HI 25
`define ISU_SUMMARY_LO 16

// command register bit positions (write one to act)
`define ISU_CMD_SOFT_RESET 0
`define ISU_CMD_TX_ENABLE 1
`define ISU_CMD_TX_RESET 2
`define ISU_CMD_RX_RESET 3
`define ISU_CMD_SW_INT 7
// command register read-back bit positions
`define ISU_CMD_TX_RUNNING 8
`define ISU_CMD_TX_RESET_PEND 9
`define ISU_CMD_RX_RESET_PEND 10

`endif

/* File: logic/isu_event_reg.v */
// sticky event flag bank with a set-over-clear priority
// assumes set and clear vectors are synchronous to clk
`timescale 1ns/1ps
`default_nettype none

module isu_event_reg #(
    parameter WIDTH = 32,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire soft_rst,
    input wire [WIDTH-1:0] set_vec,
    input wire [WIDTH-1:0] clr_vec,
    output wire [WIDTH-1:0] flags
);

    reg [WIDTH-1:0] flags_reg;
    reg [WIDTH-1:0] flags_next;

    // a set arriving with its clear wins, so no event is dropped
    always @* begin
        if (soft_rst) begin
            flags_next = RESET_VAL;
        end else begin
            flags_next = (flags_reg & ~clr_vec) | set_vec;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_reg <= RESET_VAL;
        end else if (ce) begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg;

endmodule

`default_nettype wire

/* File: verif/isu_checker_assertions.sv */
// assertions on isu_top ports: bus answer, status view, event capture
// assumes a single pclk domain; bound onto every isu_top instance
`timescale 1ns/1ps
`default_nettype none
`include "isu_defs.vh"
module isu_checker #(
    parameter ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclken,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic soft_reset,
    input wire logic system_error_signalled,
    input wire logic phy_irq,
    input wire logic tx_desc_fetched,
    input wire logic tx_desc_link_null,
    input wire logic tx_desc_owned,
    input wire logic irq_n,
    input wire logic tx_reset_req,
    input wire logic tx_engine_run
);
    wire logic acc = psel && penable && pclken;
    wire logic st_rd = acc && !pwrite && (paddr == `ISU_STATUS_OFFSET);
    wire logic mapped = (paddr == `ISU_CMD_OFFSET) ||
        (paddr == `ISU_STATUS_OFFSET) || (paddr == `ISU_MASK_OFFSET);
    // a soft reset in the same write would cancel the request
    wire logic cmd_wr = acc && pready && pwrite && !pwdata[0] &&
        pstrb[0] && (paddr == `ISU_CMD_OFFSET);
    wire logic eol = tx_desc_fetched && (tx_desc_link_null || !tx_desc_owned);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pready_single: assert property (pready && pclken |=> !pready)
        else $error("pready stood longer than one cycle");
    a_pready_wait: assert property (acc && !pready |=> pready)
        else $error("no answer one cycle into the access phase");
    a_unmapped_err: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr disagrees with the address map");
    a_status_zeros: assert property (
        pready && st_rd |-> (prdata & 32'hFC0E00FF) == 32'h0)
        else $error("reserved status bit read as one");
    a_summary_or: assert property (
        pready && st_rd |-> prdata[15] == |prdata[25:16])
        else $error("summary bit is not the or of bits 25 to 16");
    a_syserr_seen: assert property (
        system_error_signalled && pclken && !soft_reset ##1
        st_rd && !pready && !soft_reset |=> prdata[22])
        else $error("system error event missing from status read");
    a_phy_seen: assert property (
        pready && st_rd && $past(phy_irq, 2) && $past(pclken, 2) &&
        !$past(soft_reset, 2) && !$past(soft_reset) |-> prdata[14])
        else $error("phy event missing from status read");
    a_irq_reset_quiet: assert property (
        $rose(presetn) |-> irq_n ##1 irq_n)
        else $error("interrupt active with mask cleared by reset");
    a_txreq_follows: assert property (
        cmd_wr && pwdata[`ISU_CMD_TX_RESET] && !soft_reset |=> tx_reset_req)
        else $error("transmit reset request did not follow command");
    a_tx_idle_eol: assert property (
        tx_engine_run && eol && pclken && !soft_reset && !cmd_wr
        |=> !tx_engine_run)
        else $error("transmit engine kept running at end of list");
endmodule

bind isu_top isu_checker #(.ADDR_W(ADDR_W)) i_chk (
    .pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pstrb(pstrb),
    .soft_reset(soft_reset), .system_error_signalled(system_error_signalled),
    .phy_irq(phy_irq), .tx_desc_fetched(tx_desc_fetched),
    .tx_desc_link_null(tx_desc_link_null), .tx_desc_owned(tx_desc_owned),
    .irq_n(irq_n), .tx_reset_req(tx_reset_req), .tx_engine_run(tx_engine_run)
);
`default_nettype wire

/* File: verif/isu_host.sv */
// apb master standing in for host software
// assumes an apb slave on pclk; waits at most 16 cycles for pready
`timescale 1ns/1ps
`default_nettype none
module isu_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
    end

    // ok stays low when the slave never answers
    task automatic xfer(input logic wr, input logic [7:0] a,
            input logic [31:0] wd, output logic [31:0] rd,
            output logic err, output logic ok);
        int n;
        ok = 1'b0;
        rd = 32'h0;
        err = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16 && !ok; n++) begin
            @(posedge pclk);
            if (pready) begin
                ok = 1'b1;
                rd = prdata;
                err = pslverr;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking bench for isu_top against a bit-level status model
// assumes isu_host as bus master and the bound isu_checker
`timescale 1ns/1ps
`default_nettype none
`include "isu_defs.vh"
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic soft_reset = 1'b0;
    logic parity = 1'b0;
    logic fetched = 1'b0;
    logic link_null = 1'b0;
    logic owned = 1'b1;
    logic [10:0] ev = 11'h0;
    logic psel, penable, pwrite, pready, pslverr, irq_n, err, ok;
    logic tx_req, rx_req, run;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, msk;
    logic [3:0] pstrb;
    int errors = 0;
    int n_checks = 0;
    int unsigned exp_st;
    int evbit[11] = '{22, 21, 20, 16, 14, 13, 11, 10, 8, 25, 24};

    always #5 pclk = ~pclk;

    isu_host i_host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    isu_top i_dut (.pclk(pclk), .presetn(presetn), .pclken(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .soft_reset(soft_reset),
        .tx_reset_finished(ev[9]), .rx_reset_finished(ev[10]),
        .parity_error_seen(parity), .system_error_signalled(ev[0]),
        .master_abort_received(ev[1]), .target_abort_received(ev[2]),
        .rx_status_fifo_overflow(ev[3]), .phy_irq(ev[4]),
        .wake_on_network(ev[5]), .statistics_threshold_event(ev[6]),
        .tx_fifo_underflow(ev[7]), .tx_frame_failed(ev[8]),
        .tx_desc_fetched(fetched), .tx_desc_link_null(link_null),
        .tx_desc_owned(owned), .irq_n(irq_n), .tx_reset_req(tx_req),
        .rx_reset_req(rx_req), .tx_engine_run(run));

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            errors++;
            $display("MISMATCH at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
            input logic [31:0] wd);
        i_host.xfer(wr, a, wd, rd, err, ok);
        chk({31'h0, ok}, 32'h1);
        if (!ok) begin
            end_sim();
        end
    endtask

    // model view: bit 15 follows bits 25 to 16
    function automatic logic [31:0] view(input int unsigned s);
        logic [31:0] v;
        v = s;
        v[15] = |v[25:16];
        return v;
    endfunction

    task automatic rd_status;
        bus(1'b0, `ISU_STATUS_OFFSET, 32'h0);
        chk(rd, view(exp_st));
        exp_st = 0;
    endtask

    task automatic pulse(input int i);
        @(posedge pclk);
        ev[i] <= 1'b1;
        @(posedge pclk);
        ev[i] <= 1'b0;
        exp_st |= 32'h1 << evbit[i];
    endtask

    task automatic fetch(input logic nul, input logic own);
        @(posedge pclk);
        fetched <= 1'b1;
        link_null <= nul;
        owned <= own;
        @(posedge pclk);
        fetched <= 1'b0;
    endtask

    task automatic irq_is(input logic want);
        repeat (2) @(posedge pclk);
        #1;
        chk({31'h0, irq_n}, {31'h0, want});
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h9917b8df));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        exp_st = `ISU_STATUS_RESET;
        rd_status;
        bus(1'b0, `ISU_MASK_OFFSET, 32'h0);
        chk(rd, `ISU_MASK_RESET);
        rd_status;
        $display("test reset values done");
        // status writes carry random data and must change nothing
        for (int i = 0; i < 9; i++) begin
            pulse(i);
            bus(1'b1, `ISU_STATUS_OFFSET, $urandom);
            irq_is(1'b1);
            rd_status;
        end
        @(posedge pclk);
        parity <= 1'b1;
        exp_st = 32'h1 << `ISU_PARITY_ERROR_SEEN;
        rd_status;
        rd_status;
        parity <= 1'b0;
        ev[0] <= 1'b1;
        ev[4] <= 1'b1;
        exp_st = 32'h00404000;
        rd_status;
        ev[0] <= 1'b0;
        ev[4] <= 1'b0;
        exp_st = 32'h00404000;
        rd_status;
        rd_status;
        $display("test event capture done");
        msk = $urandom | 32'h00400000;
        bus(1'b1, `ISU_MASK_OFFSET, msk);
        bus(1'b0, `ISU_MASK_OFFSET, 32'h0);
        chk(rd, msk);
        pulse(0);
        irq_is(1'b0);
        rd_status;
        irq_is(1'b1);
        bus(1'b1, `ISU_MASK_OFFSET, 32'hFC0E00FF);
        pulse(3);
        irq_is(1'b1);
        rd_status;
        $display("test interrupt mask done");
        bus(1'b1, `ISU_CMD_OFFSET, 32'h4);
        #1 chk({31'h0, tx_req}, 32'h1);
        pulse(9);
        bus(1'b1, `ISU_CMD_OFFSET, 32'h8);
        #1 chk({31'h0, rx_req}, 32'h1);
        pulse(10);
        rd_status;
        // finished pulse with nothing pending must be ignored
        pulse(9);
        exp_st = 0;
        rd_status;
        bus(1'b1, `ISU_CMD_OFFSET, 32'h80);
        exp_st = 32'h1 << `ISU_SOFTWARE_INTERRUPT_REQUEST;
        rd_status;
        bus(1'b1, `ISU_CMD_OFFSET, 32'h2);
        #1 chk({31'h0, run}, 32'h1);
        fetch(1'b1, 1'b1);
        #1 chk({31'h0, run}, 32'h0);
        exp_st = 32'h1 << `ISU_TX_ENGINE_IDLE;
        rd_status;
        bus(1'b1, `ISU_CMD_OFFSET, 32'h2);
        fetch(1'b0, 1'b1);
        bus(1'b0, `ISU_CMD_OFFSET, 32'h0);
        chk(rd & 32'h100, 32'h100);
        fetch(1'b0, 1'b0);
        exp_st = 32'h1 << `ISU_TX_ENGINE_IDLE;
        rd_status;
        $display("test command sources done");
        bus(1'b0, 8'h20, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        bus(1'b1, `ISU_MASK_OFFSET, $urandom);
        pulse(1);
        @(posedge pclk);
        soft_reset <= 1'b1;
        @(posedge pclk);
        soft_reset <= 1'b0;
        exp_st = `ISU_STATUS_RESET;
        rd_status;
        bus(1'b0, `ISU_MASK_OFFSET, 32'h0);
        chk(rd, `ISU_MASK_RESET);
        bus(1'b1, `ISU_CMD_OFFSET, 32'h1);
        exp_st = `ISU_STATUS_RESET;
        rd_status;
        $display("test soft reset done");
        end_sim();
    end
endmodule
`default_nettype wire
